// [verilog/aqfi_pkg.sv]
// Package of the queue flag and interrupt block: register map, field
// positions, reset values, bus response codes and the event carrier.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package aqfi_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [11:0] AQFI_OFS_STATUS = 12'h000;
  localparam logic [11:0] AQFI_OFS_ENABLE = 12'h004;
  localparam int          AQFI_ADDR_W     = 12;

  // ---------------------------------------------------------------------
  // Field positions, shared by status and enable registers
  // ---------------------------------------------------------------------
  localparam int AQFI_NUM_SRC     = 4;
  localparam int AQFI_BIT_Q1_CMPL = 0;
  localparam int AQFI_BIT_Q1_PAUS = 1;
  localparam int AQFI_BIT_Q2_CMPL = 2;
  localparam int AQFI_BIT_Q2_PAUS = 3;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [3:0] AQFI_RST_STATUS = 4'h0;
  localparam logic [3:0] AQFI_RST_ENABLE = 4'h0;

  // ---------------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------------
  localparam logic [1:0] AQFI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AQFI_RESP_SLVERR = 2'h2;

  // Result-write events from the conversion engine, one-cycle pulses.
  typedef struct packed {
    logic q2_pause;
    logic q2_complete;
    logic q1_pause;
    logic q1_complete;
  } aqfi_events_t;

  // Four interrupt request lines toward the interrupt controller.
  typedef struct packed {
    logic q2_pause;
    logic q2_complete;
    logic q1_pause;
    logic q1_complete;
  } aqfi_irqs_t;

endpackage

// [verilog/aqfi_flag_cell.sv]
// One sticky status flag with read-then-write-zero clearing.
// Assumes the read and write strobes are single-cycle pulses on aclk.
`timescale 1ns/1ns

module aqfi_flag_cell
  import aqfi_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set_evt,
  input  wire logic rd_stb,
  input  wire logic wr_stb,
  input  wire logic wr_val,
  output logic      flag
);

  logic flag_q;
  logic flag_d;
  logic armed_q;
  logic armed_d;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // The arm bit records that software saw this flag set. A fresh event
  // disarms it, so a stale zero written afterwards cannot hide the event.
  always_comb begin
    flag_d  = flag_q;
    armed_d = armed_q;
    if (rd_stb) begin
      armed_d = flag_q;
    end
    if (wr_stb) begin
      if (!wr_val && armed_q) begin
        flag_d = 1'b0;
      end
      armed_d = 1'b0;
    end
    if (set_evt) begin
      flag_d  = 1'b1;
      armed_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // Flags reset to clear and start disarmed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q  <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

  assign flag = flag_q;

endmodule // aqfi_flag_cell

// [verilog/aqfi_top.sv]
// Queue completion and pause flags with per-source interrupt requests,
// reached by software over an AXI4-Lite slave port.
// Assumes event pulses come from logic on aclk, so they are not
// resynchronised, and that the bus master keeps one write and one read
// outstanding at most.
`timescale 1ns/1ns

module aqfi_top
  import aqfi_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire aqfi_events_t           events,
  input  wire logic [AQFI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [AQFI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output aqfi_irqs_t                  irq,
  output logic                        irq_any
);

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  // Used by both the read and the write path.
  function automatic logic [1:0] aqfi_decode(
    input logic [AQFI_ADDR_W-1:0] addr
  );
    logic [AQFI_ADDR_W-1:0] word;
    word = {addr[AQFI_ADDR_W-1:2], 2'b00};
    if (word == AQFI_OFS_STATUS) begin
      aqfi_decode = 2'b01;
    end else if (word == AQFI_OFS_ENABLE) begin
      aqfi_decode = 2'b10;
    end else begin
      aqfi_decode = 2'b00;
    end
  endfunction

  logic [AQFI_NUM_SRC-1:0] flags;
  logic [AQFI_NUM_SRC-1:0] set_vec;
  logic                    status_rd;
  logic                    status_wr;
  logic [AQFI_NUM_SRC-1:0] wr_bits;

  // ---------------------------------------------------------------------
  // Write channel state
  // ---------------------------------------------------------------------
  logic                   aw_held_q;
  logic                   aw_held_d;
  logic [AQFI_ADDR_W-1:0] aw_addr_q;
  logic [AQFI_ADDR_W-1:0] aw_addr_d;
  logic                   w_held_q;
  logic                   w_held_d;
  logic [31:0]            w_data_q;
  logic [31:0]            w_data_d;
  logic                   w_lane0_q;
  logic                   w_lane0_d;
  logic                   bvalid_q;
  logic                   bvalid_d;
  logic [1:0]             bresp_q;
  logic [1:0]             bresp_d;
  logic                   awready_q;
  logic                   awready_d;
  logic                   wready_q;
  logic                   wready_d;
  logic [3:0]             enable_q;
  logic [3:0]             enable_d;
  logic                   wr_fire;
  logic [1:0]             wr_sel;

  // Address and data are caught in either order. The write acts only
  // once both are held and no response is pending, so the response
  // always follows both.
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_lane0_d = w_lane0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    enable_d  = enable_q;
    status_wr = 1'b0;
    wr_bits   = w_data_q[AQFI_NUM_SRC-1:0];
    wr_sel    = aqfi_decode(aw_addr_q);
    wr_fire   = aw_held_q && w_held_q && !bvalid_q;
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d  = 1'b1;
      w_data_d  = s_axi_wdata;
      w_lane0_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wr_sel == 2'b00) ? AQFI_RESP_SLVERR : AQFI_RESP_OKAY;
      // A write without the low byte lane touches nothing.
      if (w_lane0_q && wr_sel == 2'b10) begin
        enable_d = wr_bits;
      end
      if (w_lane0_q && wr_sel == 2'b01) begin
        status_wr = 1'b1;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_held_d;
    wready_d  = !w_held_d;
  end

  // Write channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= AQFI_RESP_OKAY;
      enable_q  <= AQFI_RST_ENABLE;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_lane0_q <= w_lane0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      enable_q  <= enable_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
    end
  end

  // ---------------------------------------------------------------------
  // Read channel state
  // ---------------------------------------------------------------------
  logic        arready_q;
  logic        arready_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic [1:0]  rd_sel;

  // The status value is captured at the same edge that arms the flags,
  // so the word software sees is what the arm bits remember, unless an event or a status write lands in that cycle.
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    status_rd = 1'b0;
    rd_sel    = aqfi_decode(s_axi_araddr);
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = AQFI_RESP_OKAY;
      rdata_d   = 32'h0000_0000;
      case (rd_sel)
        2'b01: begin
          rdata_d[AQFI_NUM_SRC-1:0] = flags;
          status_rd                 = 1'b1;
        end
        2'b10: begin
          rdata_d[AQFI_NUM_SRC-1:0] = enable_q;
        end
        default: begin
          rresp_d = AQFI_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  // Read channel registers; arready rises one edge after reset release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= AQFI_RESP_OKAY;
    end else begin
      arready_q <= arready_d | (!arready_q && !rvalid_q);
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ---------------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------------
  assign set_vec[AQFI_BIT_Q1_CMPL] = events.q1_complete;
  assign set_vec[AQFI_BIT_Q1_PAUS] = events.q1_pause;
  assign set_vec[AQFI_BIT_Q2_CMPL] = events.q2_complete;
  assign set_vec[AQFI_BIT_Q2_PAUS] = events.q2_pause;

  // One cell per source; each clears only through its own bit.
  genvar gi;
  generate
    for (gi = 0; gi < AQFI_NUM_SRC; gi = gi + 1) begin : g_flag
      aqfi_flag_cell u_cell (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_evt (set_vec[gi]),
        .rd_stb  (status_rd),
        .wr_stb  (status_wr),
        .wr_val  (wr_bits[gi]),
        .flag    (flags[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Interrupt requests
  // ---------------------------------------------------------------------
  logic [AQFI_NUM_SRC-1:0] irq_q;
  logic [AQFI_NUM_SRC-1:0] irq_d;
  logic                    any_q;
  logic                    any_d;

  // Each line is a level that stays up while its flag and its enable bit stay set; the
  // controller outside does all prioritising between the lines.
  always_comb begin
    irq_d = flags & enable_q;
    any_d = |irq_d;
  end

  // Requests are registered so the outputs come from flip-flops; this
  // costs one cycle of latency after the flag sets.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= AQFI_RST_STATUS;
      any_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      any_q <= any_d;
    end
  end

  assign irq.q1_complete = irq_q[AQFI_BIT_Q1_CMPL];
  assign irq.q1_pause    = irq_q[AQFI_BIT_Q1_PAUS];
  assign irq.q2_complete = irq_q[AQFI_BIT_Q2_CMPL];
  assign irq.q2_pause    = irq_q[AQFI_BIT_Q2_PAUS];
  assign irq_any         = any_q;

  // Bus outputs.
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule // aqfi_top

// [dv/aqfi_props.sv]
// Checker of the flag block's bus handshakes and request outputs.
// Assumes it is bound to aqfi_top and sees only that module's ports.
`timescale 1ns/1ns
module aqfi_props
  import aqfi_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire aqfi_events_t events,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [11:0]  s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire aqfi_irqs_t   irq,
  input wire logic         irq_any
);
  logic [3:0] irq_v;
  logic [3:0] ev_v;
  logic [2:0] age_q;
  logic [2:0] age_d;
  assign irq_v = irq;
  assign ev_v = events;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since the last write response; saturates so it never wraps.
  always_comb begin
    age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
    if (s_axi_bvalid && s_axi_bready) age_d = 3'h0;
  end
  always_ff @(posedge aclk) begin
    age_q <= aresetn ? age_d : 3'h7;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_IRQ_ANY: assert property (irq_any == |irq_v)
    else $error("combined request differs from the lines");
  AST_IRQ_FALL: assert property ((~irq_v & $past(irq_v)) != 4'h0
    |-> age_q <= 3'h3) else $error("request fell with no write");
  AST_IRQ_RISE: assert property ((irq_v & ~$past(irq_v)) != 4'h0
    |-> ((irq_v & ~$past(irq_v) & ~($past(ev_v, 1) | $past(ev_v, 2)
    | $past(ev_v, 3))) == 4'h0) || age_q <= 3'h3)
    else $error("request rose with no cause");
  AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_UNMAP: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[11:3] != 9'h0 |=> s_axi_rresp == AQFI_RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  AST_R_UPPER: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:4] == 28'h0) else $error("upper bits not zero");
  cover property ($rose(irq_any));
  cover property ($fell(irq_any));
  cover property (s_axi_rvalid && s_axi_rresp == AQFI_RESP_SLVERR);
endmodule // aqfi_props

bind aqfi_top aqfi_props u_aqfi_props (.aclk, .aresetn, .events,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq, .irq_any);

// [dv/aqfi_irq_sink.sv]
// Interrupt controller model: one pending latch per request line.
// Assumes the bench acknowledges the lines after servicing them.
`timescale 1ns/1ns
module aqfi_irq_sink
  import aqfi_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire aqfi_irqs_t irq,
  input  wire logic [3:0] ack,
  output logic      [3:0] pend_q
);
  logic [3:0] pend_d;
  // Each line latches alone, with no priority among them.
  always_comb begin
    pend_d = (pend_q & ~ack) | irq;
  end
  always_ff @(posedge aclk) begin
    pend_q <= aresetn ? pend_d : 4'h0;
  end
endmodule // aqfi_irq_sink

// [dv/aqfi_bench.sv]
// Self-checking bench of the queue flag block against a bit model.
// Assumes a 100 MHz clock and the design's AXI4-Lite slave timing.
`timescale 1ns/1ns
module aqfi_bench
  import aqfi_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq_any;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, r;
  logic [3:0] wstrb, ack, pend, flg, arm, en;
  logic [1:0] bresp, rresp;
  aqfi_events_t events;
  aqfi_irqs_t irq;
  int err_total, n_tests, cyc;

  aqfi_top u_aqfi_top (.aclk, .aresetn, .events,
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq, .irq_any);
  aqfi_irq_sink u_aqfi_irq_sink (.aclk, .aresetn, .irq, .ack,
    .pend_q(pend));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Bus write; the model follows read-then-write-zero clearing.
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp(bresp, a[11:3] != 0 ? AQFI_RESP_SLVERR : AQFI_RESP_OKAY);
    if (a == AQFI_OFS_STATUS && s[0]) begin
      flg &= ~(arm & ~d[3:0]);
      arm = 4'h0;
    end
    if (a == AQFI_OFS_ENABLE && s[0]) en = d[3:0];
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    cmp(rresp, a[11:3] != 0 ? AQFI_RESP_SLVERR : AQFI_RESP_OKAY);
    cmp(rdata, a == AQFI_OFS_STATUS ? flg
        : a == AQFI_OFS_ENABLE ? en : 0);
    if (a == AQFI_OFS_STATUS) arm = flg;
  endtask

  task automatic ev(input logic [3:0] e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= 4'h0;
    flg |= e;
    arm &= ~e;
  endtask

  // Let requests settle, service the controller model, then compare.
  task automatic chk();
    repeat (3) @(posedge aclk);
    ack <= 4'hF;
    @(posedge aclk);
    ack <= 4'h0;
    repeat (2) @(posedge aclk);
    cmp(irq, flg & en);
    cmp(irq_any, |(flg & en));
    cmp(pend, flg & en);
  endtask

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard, well beyond the several hundred cycles of the run.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb, ack, flg, arm, en} = 0;
    events = 4'h0;
    seed = 32'd94080;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(AQFI_OFS_STATUS);
    rd(AQFI_OFS_ENABLE);
    for (int i = 0; i < 4; i++) begin
      ev(4'h1 << i);
      chk();
      rd(AQFI_OFS_STATUS);
      wr(AQFI_OFS_ENABLE, 4'h1 << i, 4'hF);
      chk();
      wr(AQFI_OFS_STATUS, 4'hF, 4'hF);
      wr(AQFI_OFS_STATUS, 4'h0, 4'hF);
      chk();
      rd(AQFI_OFS_STATUS);
      ev(4'h1 << i);
      wr(AQFI_OFS_STATUS, 4'h0, 4'hF);
      chk();
      rd(AQFI_OFS_STATUS);
      wr(AQFI_OFS_STATUS, 4'h0, 4'hE);
      rd(AQFI_OFS_STATUS);
      wr(AQFI_OFS_STATUS, 4'h0, 4'hF);
      chk();
    end
    rd(12'h008);
    wr(12'h00C, 4'hF, 4'hF);
    repeat (60) begin
      r = xs();
      case (r[1:0])
        2'h0: ev(r[7:4]);
        2'h1: rd(AQFI_OFS_STATUS);
        2'h2: wr(AQFI_OFS_STATUS, r[11:8], 4'hF);
        default: wr(AQFI_OFS_ENABLE, r[15:12], r[19:16]);
      endcase
      chk();
    end
    tally_and_finish();
  end
endmodule // aqfi_bench
